// >>> hw/ncoa_pkg.sv
// Functional notes
// - Accumulator bits 7:0 and 15:8 are two read/write byte registers.
// - Upper accumulator register holds bits 19:16; bits 7:4 read zero.
// - Accumulator runs on oscillator ticks; multi-byte reads are not coherent.
// - Increment bits 7:0 and 15:8 are two read/write byte registers.
// - Upper increment register holds bits 19:16; bits 7:4 read zero.
// - Reset sets increment to one and clears the accumulator.
// - Shadow increment loads from all bytes at first falling tick after low write while enabled; any increment write while disabled loads it at once.
// - Each rising tick while enabled adds shadow increment to accumulator; bit 19 carry overflows.
// - Toggle mode flips the output on every overflow.
// - Pulse mode drives output active for two to the width code ticks.
// - Overflow sets a sticky flag raising an interrupt when enabled.
package ncoa_pkg;

  localparam int ACC_W = 20;
  localparam logic [7:0] OFF_ACCL = 8'h00;
  localparam logic [7:0] OFF_ACCH = 8'h04;
  localparam logic [7:0] OFF_ACCU = 8'h08;
  localparam logic [7:0] OFF_INCL = 8'h0c;
  localparam logic [7:0] OFF_INCH = 8'h10;
  localparam logic [7:0] OFF_INCU = 8'h14;
  localparam logic [7:0] OFF_CON = 8'h18;
  localparam logic [7:0] OFF_CLK = 8'h1c;
  localparam logic [7:0] OFF_ISTAT = 8'h20;
  localparam logic [7:0] OFF_IMASK = 8'h24;
  localparam logic [19:0] ACC_RESET = 20'h00000;
  localparam logic [19:0] INC_RESET = 20'h00001;
  localparam int CON_EN_BIT = 7;
  localparam int CON_OUT_BIT = 5;
  localparam int CON_POL_BIT = 4;
  localparam int CON_PFM_BIT = 0;
  localparam int CLK_PWS_LSB = 5;
  localparam int IRQ_OVF_BIT = 0;
  localparam int PCLK_PERIOD_PS = 20000;
  localparam int INTOSC_PERIOD_PS = 62500;
  localparam int INTOSC_DIV = INTOSC_PERIOD_PS / PCLK_PERIOD_PS;

  typedef enum logic [1:0] {
    CKS_DIVIDED = 2'b00,
    CKS_PCLK = 2'b01,
    CKS_EXTERNAL = 2'b10,
    CKS_RESERVED = 2'b11
  } ncoa_cks_type;

  typedef struct packed {
    logic enable;
    logic invert;
    logic pulse_mode;
    logic [2:0] pws;
    logic [1:0] cks;
  } ncoa_ctrl_type;

  typedef struct packed {
    logic rise;
    logic fall;
  } ncoa_tick_type;

endpackage : ncoa_pkg

// >>> hw/ncoa_clk_pick.sv
`timescale 1ns/1ps
module ncoa_clk_pick #(
  parameter int DIV = ncoa_pkg::INTOSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] cks,
  input wire logic ext_clk,
  output ncoa_pkg::ncoa_tick_type tick
);

  if (DIV < 2 || DIV > 255) begin : g_bad_div
    $error("Divider must lie between 2 and 255.");
  end

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(DIV / 2);

  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic ext_prev_r;
  ncoa_pkg::ncoa_tick_type tick_r;
  ncoa_pkg::ncoa_tick_type tick_nxt;
  wire div_rise = (div_cnt_r == 8'h00);
  wire div_fall = (div_cnt_r == DIV_HALF);
  wire ext_rise = ext_clk & ~ext_prev_r;
  wire ext_fall = ~ext_clk & ext_prev_r;

  assign div_cnt_nxt = (div_cnt_r == DIV_LAST) ? 8'h00 : div_cnt_r + 8'h01;

  // Running off the bus clock, the fall tick comes with the rise tick.
  always_comb begin
    case (ncoa_pkg::ncoa_cks_type'(cks))
      ncoa_pkg::CKS_DIVIDED: tick_nxt = '{rise: div_rise, fall: div_fall};
      ncoa_pkg::CKS_PCLK: tick_nxt = '{rise: 1'b1, fall: 1'b1};
      ncoa_pkg::CKS_EXTERNAL: tick_nxt = '{rise: ext_rise, fall: ext_fall};
      default: tick_nxt = '{rise: 1'b0, fall: 1'b0};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 8'h00;
      ext_prev_r <= 1'b0;
      tick_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      ext_prev_r <= ext_clk;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : ncoa_clk_pick

// >>> hw/ncoa_pulse_gen.sv
`timescale 1ns/1ps
module ncoa_pulse_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rise,
  input wire logic ovf,
  input wire logic pulse_mode,
  input wire logic [2:0] pws,
  input wire logic invert,
  output logic level_r,
  output logic out_r
);

  typedef enum logic {PG_IDLE = 1'b0, PG_ACTIVE = 1'b1} ncoa_pg_type;

  ncoa_pg_type state_r;
  ncoa_pg_type state_nxt;
  logic arm_r;
  logic arm_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic level_nxt;
  wire [7:0] width = 8'h01 << pws;
  wire start = pulse_mode & arm_r & rise;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    level_nxt = level_r;
    arm_nxt = pulse_mode & (ovf | (arm_r & ~rise));
    if (!pulse_mode) begin
      state_nxt = PG_IDLE;
      if (ovf) level_nxt = ~level_r;
    end else begin
      case (state_r)
        PG_IDLE: begin
          level_nxt = 1'b0;
        end
        PG_ACTIVE: begin
          if (rise) begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              state_nxt = PG_IDLE;
              level_nxt = 1'b0;
            end
          end
        end
        default: state_nxt = PG_IDLE;
      endcase
      if (start) begin
        state_nxt = PG_ACTIVE;
        cnt_nxt = width;
        level_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PG_IDLE;
      arm_r <= 1'b0;
      cnt_r <= 8'h00;
      level_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      arm_r <= arm_nxt;
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      out_r <= level_nxt ^ invert;
    end
  end

  a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && !pulse_mode) |=> (level_r != $past(level_r)))
    else $error("Output did not toggle on overflow.");
  a_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> (level_r && cnt_r == (8'h01 << $past(pws))))
    else $error("Pulse did not start with the coded width.");
  a_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
    (pulse_mode && state_r == PG_ACTIVE && rise && cnt_r == 8'h01 && !start)
    |=> !level_r)
    else $error("Pulse outlived its width.");
  a_polarity_out: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (out_r == (level_r ^ $past(invert))))
    else $error("Output polarity mismatch.");

endmodule : ncoa_pulse_gen

// >>> hw/ncoa_top.sv
`timescale 1ns/1ps
module ncoa_top #(
  parameter int DIV = ncoa_pkg::INTOSC_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ext_clk,
  output logic nco_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_data;

  wire setup = psel & ~penable;
  wire done = psel & penable & pready_r;
  wire wr_en = done & pwrite;
  wire hit_accl = (paddr == ncoa_pkg::OFF_ACCL);
  wire hit_acch = (paddr == ncoa_pkg::OFF_ACCH);
  wire hit_accu = (paddr == ncoa_pkg::OFF_ACCU);
  wire hit_incl = (paddr == ncoa_pkg::OFF_INCL);
  wire hit_inch = (paddr == ncoa_pkg::OFF_INCH);
  wire hit_incu = (paddr == ncoa_pkg::OFF_INCU);
  wire hit_con = (paddr == ncoa_pkg::OFF_CON);
  wire hit_clk = (paddr == ncoa_pkg::OFF_CLK);
  wire hit_istat = (paddr == ncoa_pkg::OFF_ISTAT);
  wire hit_imask = (paddr == ncoa_pkg::OFF_IMASK);
  wire hit_any = hit_accl | hit_acch | hit_accu | hit_incl | hit_inch
    | hit_incu | hit_con | hit_clk | hit_istat | hit_imask;
  wire wr_acc = wr_en & (hit_accl | hit_acch | hit_accu);
  wire wr_inc = wr_en & (hit_incl | hit_inch | hit_incu);
  wire wr_incl = wr_en & hit_incl;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [19:0] acc_r;
  logic [19:0] acc_nxt;
  logic [19:0] inc_r;
  logic [19:0] inc_nxt;
  logic [19:0] shadow_r;
  logic [19:0] shadow_nxt;
  logic pend_r;
  logic pend_nxt;
  logic ovf_r;
  logic ovf_nxt;
  ncoa_pkg::ncoa_ctrl_type ctrl_r;
  ncoa_pkg::ncoa_ctrl_type ctrl_nxt;
  logic istat_r;
  logic istat_nxt;
  logic imask_r;
  logic imask_nxt;
  logic irq_r;
  ncoa_pkg::ncoa_tick_type tick;
  logic level;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick source and output stage.

  ncoa_clk_pick #(.DIV(DIV)) u_clk_pick (
    .pclk(pclk),
    .presetn(presetn),
    .cks(ctrl_r.cks),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  ncoa_pulse_gen u_pulse_gen (
    .pclk(pclk),
    .presetn(presetn),
    .rise(tick.rise),
    .ovf(ovf_r),
    .pulse_mode(ctrl_r.pulse_mode),
    .pws(ctrl_r.pws),
    .invert(ctrl_r.invert),
    .level_r(level),
    .out_r(nco_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator.

  wire [20:0] sum = {1'b0, acc_r} + {1'b0, shadow_r};
  wire step = tick.rise & ctrl_r.enable;
  wire [19:0] acc_wr = {
    (wr_en & hit_accu) ? pwdata[3:0] : acc_r[19:16],
    (wr_en & hit_acch) ? pwdata[7:0] : acc_r[15:8],
    (wr_en & hit_accl) ? pwdata[7:0] : acc_r[7:0]
  };

  // A bus write wins over a running step; writing while enabled is
  // the caller's hazard and gives a value nobody may rely on.
  assign acc_nxt = wr_acc ? acc_wr : (step ? sum[19:0] : acc_r);
  assign ovf_nxt = step & sum[20] & ~wr_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Increment and shadow.

  assign inc_nxt = {
    (wr_en & hit_incu) ? pwdata[3:0] : inc_r[19:16],
    (wr_en & hit_inch) ? pwdata[7:0] : inc_r[15:8],
    (wr_en & hit_incl) ? pwdata[7:0] : inc_r[7:0]
  };

  // A low-byte write landing on a fall tick stays pending for the next one, and a pending
  // load outlives a disable, so the fresh value is never lost.
  assign pend_nxt = (ctrl_r.enable & wr_incl) | (pend_r & ~tick.fall);

  always_comb begin
    shadow_nxt = shadow_r;
    if (!ctrl_r.enable && wr_inc) begin
      shadow_nxt = inc_nxt;
    end else if (pend_r && tick.fall) begin
      shadow_nxt = inc_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and interrupt.

  assign ctrl_nxt = !wr_en ? ctrl_r :
    hit_con ? '{enable: pwdata[ncoa_pkg::CON_EN_BIT],
                invert: pwdata[ncoa_pkg::CON_POL_BIT],
                pulse_mode: pwdata[ncoa_pkg::CON_PFM_BIT],
                pws: ctrl_r.pws, cks: ctrl_r.cks} :
    hit_clk ? '{enable: ctrl_r.enable, invert: ctrl_r.invert,
                pulse_mode: ctrl_r.pulse_mode,
                pws: pwdata[ncoa_pkg::CLK_PWS_LSB +: 3], cks: pwdata[1:0]} :
    ctrl_r;

  wire istat_clr = wr_en & hit_istat & pwdata[ncoa_pkg::IRQ_OVF_BIT];
  // Set wins over a clear in the same cycle.
  assign istat_nxt = (istat_r & ~istat_clr) | ovf_r;
  assign imask_nxt = (wr_en & hit_imask) ? pwdata[ncoa_pkg::IRQ_OVF_BIT] : imask_r;
  wire irq_nxt = istat_nxt & imask_nxt & ctrl_nxt.enable;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  wire [7:0] con_rd = {ctrl_r.enable, 1'b0, nco_out, ctrl_r.invert,
    3'b000, ctrl_r.pulse_mode};
  wire [7:0] clk_rd = {ctrl_r.pws, 3'b000, ctrl_r.cks};

  always_comb begin
    rd_data = 32'h00000000;
    if (hit_accl) rd_data[7:0] = acc_r[7:0];
    if (hit_acch) rd_data[7:0] = acc_r[15:8];
    if (hit_accu) rd_data[3:0] = acc_r[19:16];
    if (hit_incl) rd_data[7:0] = inc_r[7:0];
    if (hit_inch) rd_data[7:0] = inc_r[15:8];
    if (hit_incu) rd_data[3:0] = inc_r[19:16];
    if (hit_con) rd_data[7:0] = con_rd;
    if (hit_clk) rd_data[7:0] = clk_rd;
    if (hit_istat) rd_data[ncoa_pkg::IRQ_OVF_BIT] = istat_r;
    if (hit_imask) rd_data[ncoa_pkg::IRQ_OVF_BIT] = imask_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flops.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit_any;
      if (setup) prdata_r <= rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= ncoa_pkg::ACC_RESET;
      inc_r <= ncoa_pkg::INC_RESET;
      shadow_r <= ncoa_pkg::INC_RESET;
      pend_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      inc_r <= inc_nxt;
      shadow_r <= shadow_nxt;
      pend_r <= pend_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      istat_r <= 1'b0;
      imask_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup_accu;
    psel && !penable && paddr == ncoa_pkg::OFF_ACCU;
  endsequence

  sequence s_setup_incu;
    psel && !penable && paddr == ncoa_pkg::OFF_INCU;
  endsequence

  a_accu_read_zero: assert property (s_setup_accu |=> prdata[31:4] == 28'h0)
    else $error("Upper accumulator read shows unused bits.");
  a_incu_read_zero: assert property (s_setup_incu |=> prdata[31:4] == 28'h0)
    else $error("Upper increment read shows unused bits.");
  a_accl_read_val: assert property (psel && !penable && paddr == ncoa_pkg::OFF_ACCL
    |=> prdata == {24'h0, $past(acc_r[7:0])})
    else $error("Low accumulator read wrong.");
  a_inch_write_val: assert property (wr_en && hit_inch
    |=> inc_r[15:8] == $past(pwdata[7:0]))
    else $error("High increment write lost.");
  a_acc_step_sum: assert property (step && !wr_acc
    |=> acc_r == $past(sum[19:0]) && ovf_r == $past(sum[20]))
    else $error("Accumulator step wrong.");
  a_shadow_load: assert property (ctrl_r.enable && pend_r && tick.fall
    |=> shadow_r == $past(inc_r))
    else $error("Shadow not loaded on fall tick.");
  a_shadow_wait: assert property (ctrl_r.enable && wr_incl && !tick.fall
    |=> pend_r && shadow_r == $past(shadow_r))
    else $error("Shadow moved before a fall tick.");
  a_shadow_direct: assert property (!ctrl_r.enable && wr_inc
    |=> shadow_r == inc_r)
    else $error("Disabled increment write missed shadow.");
  a_flag_set_hold: assert property (ovf_r |=> istat_r [*2] or
    (istat_r ##1 $past(istat_clr)))
    else $error("Overflow flag not sticky.");
  a_irq_level: assert property (istat_r && imask_r && ctrl_r.enable
    |-> irq)
    else $error("Interrupt output low with unmasked flag.");
  a_apb_answer: assert property (setup |=> pready ##1 !pready)
    else $error("Bus answer timing wrong.");

  a_acch_read_val: assert property (setup && hit_acch
    |=> prdata == {24'h0, $past(acc_r[15:8])})
    else $error("High accumulator read wrong.");
  a_accu_read_val: assert property (setup && hit_accu
    |=> prdata[3:0] == $past(acc_r[19:16]))
    else $error("Upper accumulator read wrong.");
  a_incl_read_val: assert property (setup && hit_incl
    |=> prdata == {24'h0, $past(inc_r[7:0])})
    else $error("Low increment read wrong.");
  a_inch_read_val: assert property (setup && hit_inch
    |=> prdata == {24'h0, $past(inc_r[15:8])})
    else $error("High increment read wrong.");
  a_incu_read_val: assert property (setup && hit_incu
    |=> prdata[3:0] == $past(inc_r[19:16]))
    else $error("Upper increment read wrong.");
  a_accl_write_val: assert property (wr_en && hit_accl
    |=> acc_r[7:0] == $past(pwdata[7:0]))
    else $error("Low accumulator write lost.");
  a_acch_write_val: assert property (wr_en && hit_acch
    |=> acc_r[15:8] == $past(pwdata[7:0]))
    else $error("High accumulator write lost.");
  a_accu_write_val: assert property (wr_en && hit_accu
    |=> acc_r[19:16] == $past(pwdata[3:0]))
    else $error("Upper accumulator write lost.");
  a_incl_write_val: assert property (wr_en && hit_incl
    |=> inc_r[7:0] == $past(pwdata[7:0]))
    else $error("Low increment write lost.");
  a_incu_write_val: assert property (wr_en && hit_incu
    |=> inc_r[19:16] == $past(pwdata[3:0]))
    else $error("Upper increment write lost.");
  a_acc_hold_idle: assert property (!step && !wr_acc
    |=> acc_r == $past(acc_r))
    else $error("Accumulator moved without a tick.");
  a_ovf_from_carry: assert property (ovf_r
    |-> $past(step && sum[20] && !wr_acc))
    else $error("Overflow without a carry.");
  a_shadow_hold: assert property ((!pend_r || !tick.fall)
    && (ctrl_r.enable || !wr_inc) |=> shadow_r == $past(shadow_r))
    else $error("Shadow moved with no load event.");
  a_pend_arm: assert property (ctrl_r.enable && wr_incl
    |=> pend_r)
    else $error("Low increment write did not arm a load.");
  a_pend_clear: assert property (pend_r && tick.fall && !(ctrl_r.enable && wr_incl)
    |=> !pend_r)
    else $error("Pending load not retired on a fall tick.");
  a_flag_set: assert property (ovf_r
    |=> istat_r)
    else $error("Overflow did not set the flag.");
  a_flag_clear: assert property (istat_clr && !ovf_r
    |=> !istat_r)
    else $error("Flag not cleared by a written one.");
  a_flag_hold: assert property (!ovf_r && !istat_clr
    |=> istat_r == $past(istat_r))
    else $error("Flag changed with no event.");
  a_irq_low: assert property (!(istat_r && imask_r && ctrl_r.enable)
    |-> !irq)
    else $error("Interrupt output high with no unmasked flag.");
  a_mask_write: assert property (wr_en && hit_imask
    |=> imask_r == $past(pwdata[ncoa_pkg::IRQ_OVF_BIT]))
    else $error("Mask write lost.");
  a_status_read: assert property (setup && hit_istat
    |=> prdata[ncoa_pkg::IRQ_OVF_BIT] == $past(istat_r))
    else $error("Status read wrong.");
  a_out_status: assert property (setup && hit_con
    |=> prdata[ncoa_pkg::CON_OUT_BIT] == $past(nco_out))
    else $error("Output level status wrong.");
  a_con_write: assert property (wr_en && hit_con
    |=> ctrl_r.invert == $past(pwdata[ncoa_pkg::CON_POL_BIT])
    && ctrl_r.enable == $past(pwdata[ncoa_pkg::CON_EN_BIT]))
    else $error("Control write lost.");
  a_clk_write: assert property (wr_en && hit_clk
    |=> ctrl_r.pws == $past(pwdata[ncoa_pkg::CLK_PWS_LSB +: 3]))
    else $error("Pulse width code write lost.");
  a_bad_addr: assert property (setup && !hit_any
    |=> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused.");
  a_good_addr: assert property (setup && hit_any
    |=> !pslverr)
    else $error("Mapped access refused.");
  a_pready_idle: assert property (!setup
    |=> !pready)
    else $error("Ready without a setup cycle.");

endmodule : ncoa_top

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic ext_clk = 1'b0;
  logic nco_out;
  logic irq;
  int err_count = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////////////
  always #10 pclk = ~pclk;

  // A small divider keeps the internal source quick; the scenarios use ext_clk and pclk.
  ncoa_top #(.DIV(2)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .ext_clk(ext_clk),
    .nco_out(nco_out),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("Errors %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task check_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : check_reg

  task check_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: output %b, expected %b", $time, got, exp);
    end
  endtask : check_pin

  task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb_xfer(1'b1, a, {24'h000000, d}, q, e);
  endtask : wr

  // Any address beyond the last mapped word must be refused with an error.
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic e;
    apb_xfer(1'b0, a, 32'h00000000, q, e);
    check_reg(q, {24'h000000, exp});
    check_pin(e, a > ncoa_pkg::OFF_IMASK);
  endtask : rd_chk

  // Each pulse is one rise tick then one fall tick; six cycles outlast the sync delay.
  task ext_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (6) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : ext_pulses

  task settle_pin(input logic got_sel, input logic exp);
    repeat (3) @(posedge pclk);
    check_pin(got_sel ? irq : nco_out, exp);
  endtask : settle_pin

  // Loads the accumulator while stopped, since a running write is undefined.
  task load_acc(input logic [19:0] v);
    wr(ncoa_pkg::OFF_CON, 8'h00);
    wr(ncoa_pkg::OFF_ACCL, v[7:0]);
    wr(ncoa_pkg::OFF_ACCH, v[15:8]);
    wr(ncoa_pkg::OFF_ACCU, {4'h0, v[19:16]});
  endtask : load_acc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_pin(irq, 1'b0);
    check_pin(nco_out, 1'b0);
    rd_chk(ncoa_pkg::OFF_ACCL, 8'h00);
    rd_chk(ncoa_pkg::OFF_ACCH, 8'h00);
    rd_chk(ncoa_pkg::OFF_ACCU, 8'h00);
    rd_chk(ncoa_pkg::OFF_INCL, 8'h01);
    rd_chk(ncoa_pkg::OFF_INCH, 8'h00);
    rd_chk(ncoa_pkg::OFF_INCU, 8'h00);
    rd_chk(8'h28, 8'h00);
    wr(ncoa_pkg::OFF_ACCL, 8'ha5);
    wr(ncoa_pkg::OFF_ACCH, 8'h5a);
    wr(ncoa_pkg::OFF_ACCU, 8'hff);
    rd_chk(ncoa_pkg::OFF_ACCL, 8'ha5);
    rd_chk(ncoa_pkg::OFF_ACCH, 8'h5a);
    rd_chk(ncoa_pkg::OFF_ACCU, 8'h0f);
    wr(ncoa_pkg::OFF_INCU, 8'hf3);
    wr(ncoa_pkg::OFF_INCH, 8'hc3);
    wr(ncoa_pkg::OFF_INCL, 8'h3c);
    rd_chk(ncoa_pkg::OFF_INCL, 8'h3c);
    rd_chk(ncoa_pkg::OFF_INCH, 8'hc3);
    rd_chk(ncoa_pkg::OFF_INCU, 8'h03);
    // Stopped: the increment reaches the adder with no oscillator edge at all.
    wr(ncoa_pkg::OFF_INCU, 8'h00);
    wr(ncoa_pkg::OFF_INCH, 8'h00);
    wr(ncoa_pkg::OFF_INCL, 8'h05);
    load_acc(20'h00000);
    wr(ncoa_pkg::OFF_CLK, 8'h02);
    wr(ncoa_pkg::OFF_CON, 8'h80);
    ext_pulses(3);
    // Running: a new increment must wait for a falling edge before it is used.
    wr(ncoa_pkg::OFF_INCU, 8'h00);
    wr(ncoa_pkg::OFF_INCH, 8'h00);
    wr(ncoa_pkg::OFF_INCL, 8'h10);
    @(posedge pclk);
    ext_clk <= 1'b1;
    repeat (6) @(posedge pclk);
    wr(ncoa_pkg::OFF_CON, 8'h00);
    rd_chk(ncoa_pkg::OFF_ACCL, 8'h14);
    wr(ncoa_pkg::OFF_CON, 8'h80);
    @(posedge pclk);
    ext_clk <= 1'b0;
    repeat (6) @(posedge pclk);
    ext_pulses(1);
    wr(ncoa_pkg::OFF_CON, 8'h00);
    rd_chk(ncoa_pkg::OFF_ACCL, 8'h24);
    rd_chk(ncoa_pkg::OFF_ACCU, 8'h00);
    // Wrap past bit 19 in toggle mode with the interrupt unmasked.
    load_acc(20'hffffe);
    wr(ncoa_pkg::OFF_INCL, 8'h01);
    wr(ncoa_pkg::OFF_IMASK, 8'h01);
    wr(ncoa_pkg::OFF_CON, 8'h80);
    ext_pulses(1);
    rd_chk(ncoa_pkg::OFF_ISTAT, 8'h00);
    ext_pulses(1);
    check_pin(nco_out, 1'b1);
    check_pin(irq, 1'b1);
    rd_chk(ncoa_pkg::OFF_ISTAT, 8'h01);
    rd_chk(ncoa_pkg::OFF_CON, 8'ha0);
    rd_chk(ncoa_pkg::OFF_ACCU, 8'h00);
    wr(ncoa_pkg::OFF_IMASK, 8'h00);
    settle_pin(1'b1, 1'b0);
    wr(ncoa_pkg::OFF_IMASK, 8'h01);
    settle_pin(1'b1, 1'b1);
    wr(ncoa_pkg::OFF_ISTAT, 8'h01);
    settle_pin(1'b1, 1'b0);
    rd_chk(ncoa_pkg::OFF_ISTAT, 8'h00);
    wr(ncoa_pkg::OFF_CON, 8'h90);
    settle_pin(1'b0, 1'b0);
    rd_chk(ncoa_pkg::OFF_CON, 8'h90);
    load_acc(20'hfffff);
    wr(ncoa_pkg::OFF_CON, 8'h90);
    ext_pulses(1);
    check_pin(nco_out, 1'b1);
    // Pulse mode with a width code of one: active for exactly two rise ticks.
    load_acc(20'hfffff);
    wr(ncoa_pkg::OFF_CLK, 8'h22);
    wr(ncoa_pkg::OFF_CON, 8'h81);
    ext_pulses(1);
    check_pin(nco_out, 1'b0);
    ext_pulses(1);
    check_pin(nco_out, 1'b1);
    ext_pulses(1);
    check_pin(nco_out, 1'b1);
    ext_pulses(1);
    check_pin(nco_out, 1'b0);
    // Bus-clock source: three rise ticks fall between the enable and disable writes.
    load_acc(20'h00000);
    wr(ncoa_pkg::OFF_CLK, 8'h01);
    wr(ncoa_pkg::OFF_CON, 8'h80);
    wr(ncoa_pkg::OFF_CON, 8'h00);
    rd_chk(ncoa_pkg::OFF_ACCL, 8'h03);
    stop_test();
  end
endmodule : testbench
